// >>> rtl/esm_master.sv
// Purpose: Expansion serial bus master, eight-bit full-duplex frames, two selects.
// Assumes: Inputs synchronous to clk; config sampled when start is taken.
// Notes:   start is ignored while busy; each frame is one byte out, one byte in.
`timescale 1ns/100ps
module esm_master
   import esm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       start,
   input  wire logic       target,
   input  wire logic [7:0] tx_data,
   input  esm_cfg_t        cfg,
   output logic            busy,
   output logic            done,
   output logic [7:0]      rx_data,
   output logic            sclk,
   output logic            mosi,
   input  wire logic       miso,
   output logic            peripheral_select_0_n,
   output logic            peripheral_select_1_n
);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   esm_state_t state_reg;
   esm_cfg_t   cfg_reg;
   logic       target_reg;
   logic [3:0] edge_reg;
   logic [7:0] tx_sh_reg;
   logic [7:0] rx_sh_reg;
   esm_pins_t  pins_reg;
   logic       done_reg;
   logic [7:0] rx_data_reg;
   logic       half_tick;
   logic [4:0] half_sum;
   logic [4:0] half_len;
   logic       take;
   logic       lead_edge;
   logic       shift_edge;
   logic       sample_edge;

   assign take     = (state_reg == ST_IDLE) && start;
   assign busy     = (state_reg != ST_IDLE);
   assign half_sum = {1'b0, cfg_reg.rate_sel} + HALF_MIN;
   assign half_len = (half_sum > HALF_MAX) ? HALF_MAX : half_sum;

   // Even edges lead, odd edges trail; phase picks which one samples
   assign lead_edge   = (state_reg == ST_RUN) && half_tick && !edge_reg[0];
   assign shift_edge  = (state_reg == ST_RUN) && half_tick && (edge_reg[0] ^ cfg_reg.cpha);
   assign sample_edge = (state_reg == ST_RUN) && half_tick && !(edge_reg[0] ^ cfg_reg.cpha);

   esm_rate_gen u_rate (
      .clk       (clk),
      .rstn      (rstn),
      .run       (busy),
      .half_len  (half_len),
      .half_tick (half_tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         state_reg <= ST_IDLE;
      else
         unique case (state_reg)
            ST_IDLE:  if (take) state_reg <= ST_LEAD;
            ST_LEAD:  if (half_tick) state_reg <= ST_RUN;
            ST_RUN:   if (half_tick && edge_reg == EDGE_LAST) state_reg <= ST_TRAIL;
            ST_TRAIL: if (half_tick) state_reg <= ST_IDLE;
         endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         edge_reg <= 4'h0;
      else if (state_reg != ST_RUN)
         edge_reg <= 4'h0;
      else if (half_tick)
         edge_reg <= edge_reg + 4'h1;
   end

   // Config frozen for the frame so a mode change cannot glitch the clock
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cfg_reg    <= '0;
         target_reg <= 1'b0;
      end
      else if (take)
      begin
         cfg_reg    <= cfg;
         target_reg <= target;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pins and shifting

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pins_reg  <= PINS_RESET;
         tx_sh_reg <= 8'h00;
      end
      else if (take)
      begin
         pins_reg.sel0_n <= target;
         pins_reg.sel1_n <= !target;
         if (cfg.cpha)
            tx_sh_reg <= tx_data;
         else
         begin
            pins_reg.mosi <= tx_data[7];
            tx_sh_reg     <= {tx_data[6:0], 1'b0};
         end
      end
      else if (state_reg == ST_IDLE)
         pins_reg.sclk <= cfg.cpol;
      else if (state_reg == ST_TRAIL && half_tick)
      begin
         pins_reg.sel0_n <= 1'b1;
         pins_reg.sel1_n <= 1'b1;
      end
      else if (state_reg == ST_RUN && half_tick)
      begin
         pins_reg.sclk <= lead_edge ? !cfg_reg.cpol : cfg_reg.cpol;
         if (shift_edge)
         begin
            pins_reg.mosi <= tx_sh_reg[7];
            tx_sh_reg     <= {tx_sh_reg[6:0], 1'b0};
         end
      end
   end

   // Peripheral data is only trusted while selected and clocked
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rx_sh_reg <= RX_RESET;
      else if (sample_edge)
         rx_sh_reg <= {rx_sh_reg[6:0], miso};
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         done_reg    <= 1'b0;
         rx_data_reg <= RX_RESET;
      end
      else
      begin
         done_reg <= (state_reg == ST_TRAIL) && half_tick;
         if ((state_reg == ST_TRAIL) && half_tick)
            rx_data_reg <= rx_sh_reg;
      end
   end

   assign sclk                  = pins_reg.sclk;
   assign mosi                  = pins_reg.mosi;
   assign peripheral_select_0_n = pins_reg.sel0_n;
   assign peripheral_select_1_n = pins_reg.sel1_n;
   assign done                  = done_reg;
   assign rx_data               = rx_data_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   chk_one_select: assert property (@(posedge clk) disable iff (!rstn)
      !(!peripheral_select_0_n && !peripheral_select_1_n))
      else $error("both peripheral selects low");

   chk_select_held: assert property (@(posedge clk) disable iff (!rstn)
      (busy && $past(busy) && $past(state_reg) != ST_TRAIL)
      |-> (target_reg ? !peripheral_select_1_n : !peripheral_select_0_n))
      else $error("select released during a transfer");

   // The select must follow the target taken with start, not a later one
   chk_select_follows: assert property (@(posedge clk) disable iff (!rstn)
      take |=> (target_reg ? (!peripheral_select_1_n && peripheral_select_0_n)
                           : (!peripheral_select_0_n && peripheral_select_1_n)))
      else $error("wrong peripheral selected for the frame");

   chk_idle_lines: assert property (@(posedge clk) disable iff (!rstn)
      (state_reg == ST_IDLE && $past(state_reg) == ST_IDLE)
      |-> (peripheral_select_0_n && peripheral_select_1_n && sclk == $past(cfg.cpol)))
      else $error("idle clock level or selects wrong");

   chk_start_origin: assert property (@(posedge clk) disable iff (!rstn)
      ($past(state_reg) == ST_IDLE && state_reg != ST_IDLE) |-> $past(start))
      else $error("transfer began without a start request");

   chk_sclk_source: assert property (@(posedge clk) disable iff (!rstn)
      $changed(sclk) |-> ($past(state_reg) == ST_RUN && $past(half_tick))
                         || $past(state_reg) == ST_IDLE)
      else $error("serial clock moved outside a clock edge");

   chk_sclk_toggle: assert property (@(posedge clk) disable iff (!rstn)
      (state_reg == ST_RUN && half_tick) |=> $changed(sclk))
      else $error("serial clock did not toggle on a half period");

   chk_mosi_timing: assert property (@(posedge clk) disable iff (!rstn)
      $changed(mosi) |-> $past(take) || $past(shift_edge))
      else $error("output data changed off its shift edge");

   chk_done_release: assert property (@(posedge clk) disable iff (!rstn)
      done |-> (peripheral_select_0_n && peripheral_select_1_n && !busy)
               ##1 !done)
      else $error("done without the selects released");

   chk_frame_edges: assert property (@(posedge clk) disable iff (!rstn)
      (state_reg == ST_RUN && half_tick && edge_reg == EDGE_LAST)
      |=> state_reg == ST_TRAIL && sclk == cfg_reg.cpol)
      else $error("frame did not end at idle level after sixteen edges");

endmodule : esm_master

// >>> rtl/esm_pkg.sv
// Purpose: Shared constants and types for the expansion serial bus master.
// Assumes: One 250 MHz system clock; the 24 MHz host bus rate is made by a
//          fractional tick generator on that clock.
// Notes:   Rates are quotients of 24 MHz: half period is 2..16 host ticks.
//
// Notes on behaviour
// - Exactly two active-low peripheral selects leave the master.
// - Only the master drives the serial clock; it is an output only.
// - Only the master starts a transfer, on its own start request.
// - Master-out data is our output, master-in data is our input.
// - Software sets the serial clock anywhere from 0.75 MHz to 6 MHz.
// - The serial clock is the 24 MHz host clock divided by a whole number.
// - All four clock modes are chosen by polarity and phase controls.
package esm_pkg;

   localparam int unsigned SYS_CLK_KHZ  = 250000;
   localparam int unsigned HOST_CLK_KHZ = 24000;
   localparam int unsigned SCLK_MIN_KHZ = 750;
   localparam int unsigned SCLK_MAX_KHZ = 6000;

   // Phase accumulator in MHz units: adds host rate, wraps at system rate
   localparam logic [8:0] ACC_MOD  = 9'(SYS_CLK_KHZ / 1000);
   localparam logic [8:0] ACC_STEP = 9'(HOST_CLK_KHZ / 1000);

   // Half period of the serial clock, in host ticks
   localparam logic [4:0] HALF_MIN = 5'(HOST_CLK_KHZ / (2 * SCLK_MAX_KHZ));
   localparam logic [4:0] HALF_MAX = 5'(HOST_CLK_KHZ / (2 * SCLK_MIN_KHZ));

   localparam int unsigned FRAME_BITS = 8;
   localparam logic [3:0]  EDGE_LAST  = 4'(2 * FRAME_BITS - 1);

   localparam logic [7:0]  RX_RESET   = 8'h00;

   typedef struct packed {
      logic       cpol;
      logic       cpha;
      logic [3:0] rate_sel;
   } esm_cfg_t;

   typedef struct packed {
      logic sclk;
      logic mosi;
      logic sel0_n;
      logic sel1_n;
   } esm_pins_t;

   localparam esm_pins_t PINS_RESET = '{sclk: 1'b0, mosi: 1'b0, sel0_n: 1'b1, sel1_n: 1'b1};

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_LEAD  = 2'b01,
      ST_RUN   = 2'b11,
      ST_TRAIL = 2'b10
   } esm_state_t;

endpackage : esm_pkg

// >>> rtl/esm_rate_gen.sv
// Purpose: Host bus tick and serial half-period enable generator.
// Assumes: Runs on the system clock; run is high for the whole transfer.
// Notes:   Host ticks jitter by one system cycle; the serial rate is exact on average.
`timescale 1ns/100ps
module esm_rate_gen
   import esm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       run,
   input  wire logic [4:0] half_len,
   output logic            half_tick
);

   logic [8:0] acc_reg;
   logic [8:0] acc_sum;
   logic       host_tick;
   logic [4:0] cnt_reg;

   assign acc_sum   = acc_reg + ACC_STEP;
   assign host_tick = (acc_sum >= ACC_MOD);
   assign half_tick = run && host_tick && (cnt_reg == half_len - 5'h01);

   // Fractional 24 MHz tick from the 250 MHz clock
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         acc_reg <= 9'h000;
      else
         acc_reg <= host_tick ? acc_sum - ACC_MOD : acc_sum;
   end

   // Divide host ticks down to a half period
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         cnt_reg <= 5'h00;
      else if (!run)
         cnt_reg <= 5'h00;
      else if (host_tick)
         cnt_reg <= half_tick ? 5'h00 : cnt_reg + 5'h01;
   end

   chk_host_tick_gap: assert property (@(posedge clk) disable iff (!rstn)
      host_tick |=> !host_tick [*8])
      else $error("host tick closer than the host clock period");

   chk_half_min_gap: assert property (@(posedge clk) disable iff (!rstn)
      half_tick |=> !half_tick [*8])
      else $error("serial half period shorter than the fastest rate");

endmodule : esm_rate_gen

// >>> verif/esm_periph_model.sv
// Purpose: Behavioural peripheral on the expansion serial bus.
// Assumes: Its mode follows the master's cfg for the frame.
// Notes:   A released data line shows the inverse of its last bit.
`timescale 1ns/100ps
module esm_periph_model
(
   input  wire logic       sclk,
   input  wire logic       mosi,
   input  wire logic       sel_n,
   input  wire logic       cpol,
   input  wire logic       cpha,
   input  wire logic [7:0] resp,
   output logic            miso,
   output logic [7:0]      got
);
   logic [7:0] sh;
   initial miso = 1'b0;
   ////////////////////////////////////////
   always @(negedge sel_n) // Loads its answer only when picked
   begin
      sh  = resp;
      got = 8'h00;
      if (!cpha)
      begin
         miso = sh[7];
         sh   = sh << 1;
      end
   end
   // No pull on the line, so a stale bit must not survive
   always @(posedge sel_n)
      miso = ~miso;
   always @(sclk)
      if (!sel_n) // Never starts or clocks on its own
      begin
         if ((sclk != cpol) == cpha)
         begin
            miso = sh[7];
            sh   = sh << 1;
         end
         else
            got = {got[6:0], mosi};
      end
endmodule : esm_periph_model

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the expansion serial bus master.
// Assumes: Both peripherals run the mode of the current frame.
// Notes:   Frame time is checked with a margin for host tick jitter.
`timescale 1ns/100ps
module tb_top;
   import esm_pkg::*;
   typedef struct packed {logic tgt; logic cpol; logic cpha; logic [3:0] rs;
      logic [7:0] tx; logic [7:0] rsp;} esm_row_t;
   localparam esm_row_t ROWS [5] = '{'{1'b0, 1'b0, 1'b0, 4'h0, 8'hA5, 8'h3C},
      '{1'b1, 1'b0, 1'b1, 4'h1, 8'h81, 8'h7E}, '{1'b0, 1'b1, 1'b0, 4'h5, 8'h01, 8'h80},
      '{1'b1, 1'b1, 1'b1, 4'hE, 8'hFF, 8'h00}, '{1'b0, 1'b0, 1'b0, 4'hF, 8'h5A, 8'hC3}};
   logic       clk = 1'b0;
   logic       rstn, start, target, busy, done, sclk, mosi, miso, sel0_n, sel1_n, m0, m1, prev;
   logic [7:0] tx_data, rx_data, resp0, resp1, got0, got1;
   esm_cfg_t   cfg;
   int         n_fail = 0;
   int         check_count = 0;
   int         edges, cyc;
   ////////////////////////////////////////
   always #2 clk = ~clk;
   assign miso = sel1_n ? m0 : m1;
   esm_master dut_u (.clk(clk), .rstn(rstn), .start(start), .target(target),
      .tx_data(tx_data), .cfg(cfg), .busy(busy), .done(done), .rx_data(rx_data),
      .sclk(sclk), .mosi(mosi), .miso(miso), .peripheral_select_0_n(sel0_n),
      .peripheral_select_1_n(sel1_n));
   esm_periph_model periph0_u (.sclk(sclk), .mosi(mosi), .sel_n(sel0_n), .cpol(cfg.cpol),
      .cpha(cfg.cpha), .resp(resp0), .miso(m0), .got(got0));
   esm_periph_model periph1_u (.sclk(sclk), .mosi(mosi), .sel_n(sel1_n), .cpol(cfg.cpol),
      .cpha(cfg.cpha), .resp(resp1), .miso(m1), .got(got1));
   ////////////////////////////////////////
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic end_of_test;
      if (n_fail == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test
   always @(negedge clk)
   begin
      if (busy === 1'b1 && sclk !== prev)
         edges++;
      prev = sclk;
      if (rstn === 1'b1 && (sel0_n | sel1_n) !== 1'b1)
         chk("one select", 1, 0);
   end
   // Target and data are scrambled once taken, so late sampling shows up
   task automatic frame(esm_row_t r, int poke);
      int half;
      int lo;
      half  = (r.rs > 4'hE) ? 16 : r.rs + 2;
      lo    = 18 * half * 250 / 24 - 24;
      resp0 = r.tgt ? ~r.rsp : r.rsp;
      resp1 = ~resp0;
      if (cfg.cpol !== r.cpol)
      begin
         cfg.cpol = r.cpol;
         @(negedge clk);
         chk("idle clock", r.cpol, sclk);
      end
      cfg     = '{cpol: r.cpol, cpha: r.cpha, rate_sel: r.rs};
      target  = r.tgt;
      tx_data = r.tx;
      start   = 1'b1;
      edges   = 0;
      cyc     = 0;
      do
      begin
         @(negedge clk);
         cyc++;
         // Leave the lines alone in the done cycle: the next frame drives them there
         if (done !== 1'b1)
         begin
            start   = (cyc == poke);
            target  = !r.tgt;
            tx_data = ~r.tx;
         end
         if (busy === 1'b1)
            chk("select", {!r.tgt, r.tgt}, {sel1_n, sel0_n});
      end
      while (done !== 1'b1 && cyc < 4000);
      chk("frame end", 1, done);
      chk("rx byte", r.rsp, rx_data);
      chk("tx byte", r.tx, r.tgt ? got1 : got0);
      chk("clock edges", 16, edges);
      chk("idle pins", {r.cpol, 3'b011}, {sclk, busy, sel1_n, sel0_n});
      chk("frame time", 1, (cyc > lo && cyc < lo + 48));
   endtask : frame
   ////////////////////////////////////////
   initial
   begin
      rstn    = 1'b0;
      start   = 1'b0;
      target  = 1'b0;
      tx_data = 8'h00;
      cfg     = '0;
      resp0   = 8'h00;
      resp1   = 8'h00;
      prev    = 1'b0;
      repeat (12) @(negedge clk);
      chk("reset pins", 16'h0300, {sclk, mosi, busy, done, sel1_n, sel0_n, rx_data});
      rstn = 1'b1;
      foreach (ROWS[i])
      begin
         frame(ROWS[i], -1);
         @(negedge clk);
         chk("done pulse", 0, done);
      end
      // A start during a frame is dropped; the next one lands in the done cycle
      frame('{1'b1, 1'b0, 1'b1, 4'h2, 8'h96, 8'h69}, 30);
      frame('{1'b0, 1'b0, 1'b1, 4'h2, 8'h0F, 8'hF0}, -1);
      frame('{1'b1, 1'b0, 1'b0, 4'h0, 8'hC6, 8'h39}, -1);
      @(negedge clk);
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      repeat (100) @(negedge clk);
      rstn = 1'b0;
      @(negedge clk);
      chk("abort pins", 16'h0300, {sclk, mosi, busy, done, sel1_n, sel0_n, rx_data});
      rstn = 1'b1;
      frame(ROWS[1], -1);
      end_of_test;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_of_test;
   end
endmodule : tb_top
